// *** lihm_consts.svh ***
// Constants for the link indicator and host mode select block
`ifndef LIHM_CONSTS_SVH
`define LIHM_CONSTS_SVH

// Register indices (the bus address equals the index)
`define LIHM_REG_CTRL        4'h0
`define LIHM_REG_PHY_STATUS  4'h1
`define LIHM_REG_MODE_STATUS 4'h2
`define LIHM_REG_BLINK_CFG   4'h3

// Control register fields
`define LIHM_CTRL_LOW_FREQ_BIT 0

// PHY status register fields
`define LIHM_PHY_LINK_BIT    0
`define LIHM_PHY_SPEED_BIT   1
`define LIHM_PHY_DUPLEX_BIT  2
`define LIHM_PHY_ACT_BIT     3
`define LIHM_PHY_COL_BIT     4

// Reset values
`define LIHM_CTRL_RESET      8'h00
`define LIHM_BLINK_RESET     8'h0F

// Strap patterns
`define LIHM_STRAP_SERIAL    4'h0
`define LIHM_STRAP_PAR_HI    3'h2

// Clock figures in MHz
`define LIHM_SYS_CLK_MHZ     250
`define LIHM_REF_CLK_MHZ     25
`define LIHM_FAST_CLK_MHZ    100

// Blink period unit in milliseconds per configured step
`define LIHM_BLINK_STEP_MS   1
`define LIHM_BLINK_STEP_CYC  (`LIHM_BLINK_STEP_MS * `LIHM_SYS_CLK_MHZ * 1000)

`endif

// *** lihm_pkg.sv ***
// Types shared by the link indicator and host mode select block
package lihm_pkg;

  typedef enum logic [1:0] {
    LIHM_MODE_SERIAL,
    LIHM_MODE_PARALLEL,
    LIHM_MODE_INVALID
  } lihm_host_mode_type;

  typedef struct packed {
    logic link_up;
    logic speed_100;
    logic full_duplex;
    logic activity;
    logic collision;
  } lihm_phy_status_type;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } lihm_bus_req_type;

endpackage

// *** lihm_clk_div.sv ***
// Clock enable divider for the internal operating clock strobe
`timescale 1ns/1ps
`include "lihm_consts.svh"

module lihm_clk_div #(
  parameter int SYS_MHZ = `LIHM_SYS_CLK_MHZ
) (
  input  wire logic clk_in,
  input  wire logic nrst_in,
  input  wire logic low_freq_in,
  input  wire logic ref_tick_in,
  output logic      tick_out
);

  localparam int FAST_MHZ = `LIHM_FAST_CLK_MHZ;

  // Tick spacing relies on at least two system cycles per fast tick
  if (SYS_MHZ < 2 * FAST_MHZ || SYS_MHZ > 32767) begin : g_bad_sys_clk
    $error("System clock outside the range the tick logic can serve");
  end

  logic [15:0] acc_reg;
  logic [15:0] acc_next;
  logic [15:0] acc_sum;
  logic        tick_reg;
  logic        tick_next;

  // Phase accumulator, fast ticks average the exact fast rate
  always_comb begin
    acc_sum   = acc_reg + 16'(FAST_MHZ);
    acc_next  = acc_sum;
    tick_next = 1'b0;
    if (low_freq_in) begin
      acc_next  = 16'h0000;
      tick_next = ref_tick_in & ~tick_reg;
    end else if (acc_sum >= 16'(SYS_MHZ)) begin
      acc_next  = acc_sum - 16'(SYS_MHZ);
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      acc_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_out = tick_reg;

endmodule

// *** lihm_top.sv ***
// Network indicator drivers, host mode strap decode and clock select
//
// Overview of operation
// RL1: Indicators behave identically in serial and parallel modes
// RL2: Link up, idle: activity indicator held low
// RL3: Traffic blinks activity; link down drives high
// RL4: Collision drives collision indicator low, else high
// RL5: Strap 0000 is serial, 010X is parallel
// RL6: Internal clock from 25 MHz reference, 25/100; here only the 25 MHz tick uses it, the 100 MHz tick is divided from CLK_IN
// RL7: Link, speed, duplex indicators low when asserted
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "lihm_consts.svh"

module lihm_top
  import lihm_pkg::*;
#(
  parameter int BLINK_STEP_CYC = `LIHM_BLINK_STEP_CYC
) (
  input  wire logic                          CLK_IN,
  input  wire logic                          NRST_IN,
  input  wire lihm_pkg::lihm_phy_status_type PHY_STATUS_IN,
  input  wire logic [3:0]                    HOST_MODE_STRAP_IN,
  input  wire logic                          REFERENCE_CLOCK_IN,
  input  wire logic [3:0]                    ADDR_IN,
  input  wire logic [7:0]                    WDATA_IN,
  input  wire logic                          WR_IN,
  input  wire logic                          RD_IN,
  output logic [7:0]                         RDATA_OUT,
  output logic                               LINK_UP_INDICATOR_N_OUT,
  output logic                               SPEED_INDICATOR_N_OUT,
  output logic                               DUPLEX_INDICATOR_N_OUT,
  output logic                               TRAFFIC_ACTIVITY_INDICATOR_N_OUT,
  output logic                               COLLISION_INDICATOR_N_OUT,
  output logic                               SERIAL_MODE_OUT,
  output logic                               PARALLEL_MODE_OUT,
  output logic                               SYS_TICK_OUT
);

  import lihm_pkg::*;

  if (BLINK_STEP_CYC < 1) begin : g_bad_step
    $error("Blink step must be at least one cycle");
  end

  // Bus request bundle
  lihm_bus_req_type req;
  assign req = '{wr: WR_IN, rd: RD_IN, addr: ADDR_IN, wdata: WDATA_IN};

  // Registers
  logic               low_freq_reg;
  logic               low_freq_next;
  logic [7:0]         blink_cfg_reg;
  logic [7:0]         blink_cfg_next;
  logic [7:0]         rdata_reg;
  logic [7:0]         rdata_next;
  lihm_host_mode_type mode_reg;
  lihm_host_mode_type mode_next;
  logic               strap_taken_reg;
  logic               strap_taken_next;
  logic               ref_d1_reg;
  logic               ref_d2_reg;
  logic               ref_d3_reg;
  logic [31:0]        step_cnt_reg;
  logic [31:0]        step_cnt_next;
  logic [7:0]         blink_cnt_reg;
  logic [7:0]         blink_cnt_next;
  logic               blink_phase_reg;
  logic               blink_phase_next;
  logic               link_n_reg;
  logic               link_n_next;
  logic               spd_n_reg;
  logic               spd_n_next;
  logic               dpx_n_reg;
  logic               dpx_n_next;
  logic               act_n_reg;
  logic               act_n_next;
  logic               col_n_reg;
  logic               col_n_next;
  logic               ser_reg;
  logic               ser_next;
  logic               par_reg;
  logic               par_next;
  logic               ref_tick;
  logic               sys_tick;

  // Register file
  always_comb begin
    low_freq_next  = low_freq_reg;
    blink_cfg_next = blink_cfg_reg;
    rdata_next     = 8'h00;
    if (req.wr) begin
      case (req.addr)
        `LIHM_REG_CTRL:      low_freq_next  = req.wdata[`LIHM_CTRL_LOW_FREQ_BIT];
        `LIHM_REG_BLINK_CFG: blink_cfg_next = req.wdata;
        default:             low_freq_next  = low_freq_reg;
      endcase
    end
    if (req.rd) begin
      case (req.addr)
        `LIHM_REG_CTRL:        rdata_next = {7'h00, low_freq_reg};
        `LIHM_REG_PHY_STATUS:  rdata_next = {3'h0, ~col_n_reg, ~act_n_reg, ~dpx_n_reg, ~spd_n_reg, ~link_n_reg};
        `LIHM_REG_MODE_STATUS: rdata_next = {6'h00, par_reg, ser_reg};
        `LIHM_REG_BLINK_CFG:   rdata_next = blink_cfg_reg;
        default:               rdata_next = 8'h00;
      endcase
    end
  end

  // Strap decode, caught once after reset release
  always_comb begin
    strap_taken_next = 1'b1;
    mode_next        = mode_reg;
    if (!strap_taken_reg) begin
      if (HOST_MODE_STRAP_IN == `LIHM_STRAP_SERIAL) begin
        mode_next = LIHM_MODE_SERIAL; // see RL5
      end else if (HOST_MODE_STRAP_IN[3:1] == `LIHM_STRAP_PAR_HI) begin
        mode_next = LIHM_MODE_PARALLEL; // see RL5
      end else begin
        mode_next = LIHM_MODE_INVALID;
      end
    end
    ser_next = (mode_next == LIHM_MODE_SERIAL);
    par_next = (mode_next == LIHM_MODE_PARALLEL);
  end

  // Reference edge detect from synchronised reference
  assign ref_tick = ref_d2_reg & ~ref_d3_reg;

  lihm_clk_div #(
    .SYS_MHZ (`LIHM_SYS_CLK_MHZ)
  ) u_clk_div (
    .clk_in      (CLK_IN),
    .nrst_in     (NRST_IN),
    .low_freq_in (low_freq_reg),
    .ref_tick_in (ref_tick),
    .tick_out    (sys_tick)
  ); // see RL6

  // Blink timing and indicators, independent of host mode
  always_comb begin
    step_cnt_next    = step_cnt_reg;
    blink_cnt_next   = blink_cnt_reg;
    blink_phase_next = blink_phase_reg;
    if (step_cnt_reg >= 32'(BLINK_STEP_CYC - 1)) begin
      step_cnt_next = 32'h0000_0000;
      if (blink_cnt_reg >= blink_cfg_reg) begin
        blink_cnt_next   = 8'h00;
        blink_phase_next = ~blink_phase_reg;
      end else begin
        blink_cnt_next = blink_cnt_reg + 8'h01;
      end
    end else begin
      step_cnt_next = step_cnt_reg + 32'h0000_0001;
    end
    link_n_next = ~PHY_STATUS_IN.link_up;     // see RL7, RL1
    spd_n_next  = ~PHY_STATUS_IN.speed_100;   // see RL7
    dpx_n_next  = ~PHY_STATUS_IN.full_duplex; // see RL7
    col_n_next  = ~PHY_STATUS_IN.collision;   // see RL4
    if (!PHY_STATUS_IN.link_up) begin
      act_n_next = 1'b1; // see RL3
    end else if (PHY_STATUS_IN.activity) begin
      act_n_next = blink_phase_reg; // see RL3
    end else begin
      act_n_next = 1'b0; // see RL2
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!NRST_IN) begin
      low_freq_reg    <= 1'b0;
      blink_cfg_reg   <= `LIHM_BLINK_RESET;
      rdata_reg       <= 8'h00;
      mode_reg        <= LIHM_MODE_INVALID;
      strap_taken_reg <= 1'b0;
      ser_reg         <= 1'b0;
      par_reg         <= 1'b0;
      ref_d1_reg      <= 1'b0;
      ref_d2_reg      <= 1'b0;
      ref_d3_reg      <= 1'b0;
      step_cnt_reg    <= 32'h0000_0000;
      blink_cnt_reg   <= 8'h00;
      blink_phase_reg <= 1'b0;
      link_n_reg      <= 1'b1;
      spd_n_reg       <= 1'b1;
      dpx_n_reg       <= 1'b1;
      act_n_reg       <= 1'b1;
      col_n_reg       <= 1'b1;
    end else begin
      low_freq_reg    <= low_freq_next;
      blink_cfg_reg   <= blink_cfg_next;
      rdata_reg       <= rdata_next;
      mode_reg        <= mode_next;
      strap_taken_reg <= strap_taken_next;
      ser_reg         <= ser_next;
      par_reg         <= par_next;
      ref_d1_reg      <= REFERENCE_CLOCK_IN;
      ref_d2_reg      <= ref_d1_reg;
      ref_d3_reg      <= ref_d2_reg;
      step_cnt_reg    <= step_cnt_next;
      blink_cnt_reg   <= blink_cnt_next;
      blink_phase_reg <= blink_phase_next;
      link_n_reg      <= link_n_next;
      spd_n_reg       <= spd_n_next;
      dpx_n_reg       <= dpx_n_next;
      act_n_reg       <= act_n_next;
      col_n_reg       <= col_n_next;
    end
  end

  assign RDATA_OUT                        = rdata_reg;
  assign LINK_UP_INDICATOR_N_OUT          = link_n_reg;
  assign SPEED_INDICATOR_N_OUT            = spd_n_reg;
  assign DUPLEX_INDICATOR_N_OUT           = dpx_n_reg;
  assign TRAFFIC_ACTIVITY_INDICATOR_N_OUT = act_n_reg;
  assign COLLISION_INDICATOR_N_OUT        = col_n_reg;
  assign SERIAL_MODE_OUT                  = ser_reg;
  assign PARALLEL_MODE_OUT                = par_reg;
  assign SYS_TICK_OUT                     = sys_tick;

endmodule

// *** lihm_checker.sv ***
// Assertion checker for the indicator and mode select block
`timescale 1ns/1ps
module lihm_checker
  import lihm_pkg::*;
(
  input wire logic                          CLK_IN,
  input wire logic                          NRST_IN,
  input wire lihm_pkg::lihm_phy_status_type PHY_STATUS_IN,
  input wire logic [3:0]                    HOST_MODE_STRAP_IN,
  input wire logic [3:0]                    ADDR_IN,
  input wire logic                          RD_IN,
  input wire logic [7:0]                    RDATA_OUT,
  input wire logic                          LINK_UP_INDICATOR_N_OUT,
  input wire logic                          SPEED_INDICATOR_N_OUT,
  input wire logic                          DUPLEX_INDICATOR_N_OUT,
  input wire logic                          TRAFFIC_ACTIVITY_INDICATOR_N_OUT,
  input wire logic                          COLLISION_INDICATOR_N_OUT,
  input wire logic                          SERIAL_MODE_OUT,
  input wire logic                          PARALLEL_MODE_OUT,
  input wire logic                          SYS_TICK_OUT
);
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (!NRST_IN);
  // Out of reset for at least one edge
  sequence s_run;
    NRST_IN && $past(NRST_IN);
  endsequence
  a_link_follow: assert property (s_run |-> LINK_UP_INDICATOR_N_OUT == !$past(PHY_STATUS_IN.link_up))
    else $error("link indicator wrong");
  a_speed_follow: assert property (s_run |-> SPEED_INDICATOR_N_OUT == !$past(PHY_STATUS_IN.speed_100))
    else $error("speed indicator wrong");
  a_duplex_follow: assert property (s_run |-> DUPLEX_INDICATOR_N_OUT == !$past(PHY_STATUS_IN.full_duplex))
    else $error("duplex indicator wrong");
  a_coll_follow: assert property (s_run |-> COLLISION_INDICATOR_N_OUT == !$past(PHY_STATUS_IN.collision))
    else $error("collision indicator wrong");
  a_act_down: assert property (s_run ##0 !$past(PHY_STATUS_IN.link_up) |-> TRAFFIC_ACTIVITY_INDICATOR_N_OUT)
    else $error("activity not high on link down");
  a_act_idle: assert property (s_run ##0 $past(PHY_STATUS_IN.link_up) && !$past(PHY_STATUS_IN.activity)
    |-> !TRAFFIC_ACTIVITY_INDICATOR_N_OUT) else $error("activity not steady low when idle");
  a_serial_decode: assert property ($past(NRST_IN, 2) && $past(NRST_IN) |-> SERIAL_MODE_OUT == (HOST_MODE_STRAP_IN == 4'h0))
    else $error("serial mode decode wrong");
  a_par_decode: assert property ($past(NRST_IN, 2) && $past(NRST_IN)
    |-> PARALLEL_MODE_OUT == (HOST_MODE_STRAP_IN[3:1] == 3'h2)) else $error("parallel mode decode wrong");
  a_mode_read: assert property (s_run ##0 $past(NRST_IN, 2) && $past(RD_IN) && $past(ADDR_IN) == 4'h2
    |-> RDATA_OUT == {6'h00, PARALLEL_MODE_OUT, SERIAL_MODE_OUT}) else $error("mode status read wrong");
  a_tick_gap: assert property (SYS_TICK_OUT |=> !SYS_TICK_OUT)
    else $error("internal tick too fast");
endmodule

bind lihm_top lihm_checker i_lihm_checker (
  .CLK_IN(CLK_IN), .NRST_IN(NRST_IN), .PHY_STATUS_IN(PHY_STATUS_IN), .HOST_MODE_STRAP_IN(HOST_MODE_STRAP_IN),
  .ADDR_IN(ADDR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .LINK_UP_INDICATOR_N_OUT(LINK_UP_INDICATOR_N_OUT),
  .SPEED_INDICATOR_N_OUT(SPEED_INDICATOR_N_OUT), .DUPLEX_INDICATOR_N_OUT(DUPLEX_INDICATOR_N_OUT),
  .TRAFFIC_ACTIVITY_INDICATOR_N_OUT(TRAFFIC_ACTIVITY_INDICATOR_N_OUT),
  .COLLISION_INDICATOR_N_OUT(COLLISION_INDICATOR_N_OUT), .SERIAL_MODE_OUT(SERIAL_MODE_OUT),
  .PARALLEL_MODE_OUT(PARALLEL_MODE_OUT), .SYS_TICK_OUT(SYS_TICK_OUT));

// *** lihm_board.sv ***
// Board model: mode straps and the 25 MHz reference oscillator
`timescale 1ns/1ps
module lihm_board (
  input  wire logic [3:0] strap_sel_in,
  output logic      [3:0] strap_out,
  output logic            ref_clk_out
);
  assign strap_out = strap_sel_in;
  initial begin
    ref_clk_out = 1'h0;
    forever #20 ref_clk_out = ~ref_clk_out;
  end
endmodule

// *** lihm_top_test.sv ***
// Self-checking bench for the indicator and mode select block
`timescale 1ns/1ps
module lihm_top_test;
  import lihm_pkg::*;
  logic                clk       = 1'h0;
  logic                nrst      = 1'h0;
  lihm_phy_status_type phy       = '0;
  logic [3:0]          strap_sel = 4'h0;
  logic [3:0]          addr      = 4'h0;
  logic [7:0]          wdata     = 8'h00;
  logic                wr        = 1'h0;
  logic                rd        = 1'h0;
  wire logic [3:0]     strap;
  wire logic           ref_clk;
  wire logic [7:0]     rdata;
  wire logic [4:0]     ind;
  wire logic           tick;
  int                  err_count = 0;
  int                  n_tests   = 0;
  int                  n;

  lihm_board i_lihm_board (.strap_sel_in(strap_sel), .strap_out(strap), .ref_clk_out(ref_clk));
  lihm_top #(.BLINK_STEP_CYC(4)) i_lihm_top (
    .CLK_IN(clk), .NRST_IN(nrst), .PHY_STATUS_IN(phy), .HOST_MODE_STRAP_IN(strap), .REFERENCE_CLOCK_IN(ref_clk),
    .ADDR_IN(addr), .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
    .LINK_UP_INDICATOR_N_OUT(ind[4]), .SPEED_INDICATOR_N_OUT(ind[3]), .DUPLEX_INDICATOR_N_OUT(ind[2]),
    .TRAFFIC_ACTIVITY_INDICATOR_N_OUT(ind[1]), .COLLISION_INDICATOR_N_OUT(ind[0]),
    .SERIAL_MODE_OUT(), .PARALLEL_MODE_OUT(), .SYS_TICK_OUT(tick));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic finish_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'h1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'h0;
  endtask

  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'h1;
    addr <= a;
    @(posedge clk);
    rd <= 1'h0;
    #1 check(rdata, exp);
  endtask

  task automatic do_reset(input logic [3:0] s);
    @(posedge clk);
    nrst <= 1'h0;
    strap_sel <= s;
    repeat (4) @(posedge clk);
    nrst <= 1'h1;
    repeat (3) @(posedge clk);
  endtask

  // Counts activity toggles (sel 0) or tick pulses (sel 1)
  task automatic count(input int sel, input int cyc, output int k);
    logic prev;
    #1;
    prev = ind[1];
    k = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1 k += (sel == 0) ? int'(ind[1] !== prev) : int'(tick === 1'h1);
      prev = ind[1];
    end
  endtask

  task automatic sweep();
    logic [4:0] v;
    for (int i = 0; i < 32; i++) begin
      @(posedge clk);
      phy <= i[4:0];
      v = ~i[4:0];
      @(posedge clk);
      #1 check(8'(ind[4:2]), 8'(v[4:2]));
      check(8'(ind[0]), 8'(v[0]));
      if (!(i[4] && i[1])) check(8'(ind[1]), 8'(v[4]));
    end
  endtask

  initial begin
    do_reset(4'h0);
    rd_chk(4'h2, 8'h01);
    rd_chk(4'h3, 8'h0F);
    wr_reg(4'h7, 8'hFF);
    rd_chk(4'h7, 8'h00);
    sweep();
    @(posedge clk);
    phy <= 5'h18;
    rd_chk(4'h1, 8'h0B);
    for (int c = 0; c < 2; c++) begin
      wr_reg(4'h3, c[7:0]);
      @(posedge clk);
      phy <= 5'h12;
      repeat (10) @(posedge clk);
      count(0, 80, n);
      check(8'(n), 8'(20 / (c + 1)));
    end
    count(1, 40, n);
    check(8'(n), 8'h10);
    wr_reg(4'h0, 8'h01);
    repeat (10) @(posedge clk);
    count(1, 80, n);
    check(8'(n >= 7 && n <= 9), 8'h01);
    do_reset(4'h5);
    rd_chk(4'h2, 8'h02);
    sweep();
    do_reset(4'h4);
    rd_chk(4'h2, 8'h02);
    do_reset(4'hF);
    rd_chk(4'h2, 8'h00);
    finish_test();
  end

  initial begin
    #200000;
    err_count++;
    finish_test();
  end
endmodule
